/* File: igm_defines.svh */
// Constants for the I2C gain and mode slave: address, field positions, resets, timing.
// Assumes a single 250 MHz system clock; included by bare name.
`ifndef IGM_DEFINES_SVH
`define IGM_DEFINES_SVH

`define IGM_DEV_ADDR_BYTE      8'hDE
`define IGM_SEL_BIT            7
`define IGM_MODE_PWR_BIT       0
`define IGM_MODE_MUTE_BIT      1
`define IGM_MODE_TEST_BIT      4
`define IGM_GAIN_WIDTH         6
`define IGM_MODE_RESET         8'h00
`define IGM_GAIN_RESET         6'h00
`define IGM_CLK_MHZ            250
`define IGM_WAKE_MS            5
`define IGM_WAKE_CYCLES        (`IGM_WAKE_MS * 1000 * `IGM_CLK_MHZ)

`endif

/* File: igm_pkg.sv */
// Types shared by the I2C gain and mode slave files.
// No constants here; numbers live in igm_defines.svh.
package igm_pkg;
  typedef enum logic [4:0] {
    IGM_IDLE = 5'h01,
    IGM_ADDR = 5'h02,
    IGM_AACK = 5'h04,
    IGM_DATA = 5'h08,
    IGM_DACK = 5'h10
  } igm_state_t;
endpackage : igm_pkg

/* File: igm_line_if.sv */
// Interface carrying sampled bus levels and detected bus events.
// Assumes both sides run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface igm_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic start_det;
  logic stop_det;
  modport det (output scl_rise, output scl_fall, output sda_level,
               output start_det, output stop_det);
  modport core (input scl_rise, input scl_fall, input sda_level,
                input start_det, input stop_det);
endinterface : igm_line_if
`default_nettype wire

/* File: igm_line_detect.sv */
// Edge and START/STOP detector for the serial clock and data lines.
// Assumes scl_in and sda_in are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module igm_line_detect (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  igm_line_if.det   line
);
  logic scl_ff;
  logic sda_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl_in;
      sda_ff <= sda_in;
    end
  end

  assign line.scl_rise  = scl_in & ~scl_ff;
  assign line.scl_fall  = ~scl_in & scl_ff;
  assign line.sda_level = sda_in;
  assign line.start_det = scl_in & scl_ff & sda_ff & ~sda_in;
  assign line.stop_det  = scl_in & scl_ff & ~sda_ff & sda_in;
endmodule : igm_line_detect
`default_nettype wire

/* File: igm_slave.sv */
// Write-only I2C slave holding the mode and gain control registers.
// Assumes SCL/SDA inputs are already synchronous to clk_sys; SDA open drain.
// What this block does
// - Pure slave, never drives clock; works for any master clock up to 400 kHz.
// - A high-to-low data change while clock high starts an address byte.
// - Only address byte 11011110 is answered.
// - A read request is never acknowledged.
// - Address bits are captured on the rising clock edge.
// - Matching address is acknowledged by holding data low through clock nine.
// - Every byte is eight bits plus an acknowledge slot; the slave drives it only after a matching address.
// - Data byte top bit picks mode register (0) or gain register (1).
// - Any number of data bytes per transfer, each acknowledged and applied.
// - Mode bit 0 low is power-down, resets low; wake-up takes 5 ms.
// - Mode bit 1 high mutes the output; resets low.
// - Mode bit 4 enables factory test; resets low; master writes zero.
// - Reserved mode bits 2,3,5,6 and gain bit 6 are ignored.
// - Gain byte loads its low six bits as gain code, reset zero.
// - Gain code 0 mutes, 1 is minimum gain, 63 is maximum gain.
// - After STOP all bus activity is ignored until START and matching address.
`timescale 1ns/1ps
`default_nettype none
`include "igm_defines.svh"
module igm_slave #(
  parameter int unsigned WAKE_CYCLES = `IGM_WAKE_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            power_down_select,
  output logic            mute_enable,
  output logic            factory_test_enable,
  output logic [5:0]      gain_code,
  output logic            amp_ready,
  output logic            busy
);
  igm_line_if line ();

  // Clock is input only; 250 MHz sampling covers 400 kHz easily
  igm_line_detect u_det (
    .clk_sys (clk_sys),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .line    (line)
  );

  igm_pkg::igm_state_t state_ff;
  igm_pkg::igm_state_t nxt_state;
  logic [7:0]          shift_ff;
  logic [3:0]          bit_cnt_ff;
  logic                ack_drive_ff;
  logic                power_ff;
  logic                mute_ff;
  logic                test_ff;
  logic [5:0]          gain_ff;
  logic [31:0]         wake_cnt_ff;
  logic                ready_ff;
  logic                commit;
  logic                in_addr;
  logic                in_aack;
  logic                in_data;
  logic                in_dack;
  logic                in_byte;
  logic                in_ack;
  logic                bus_event;
  logic                byte_full;
  logic                take_bit;
  logic                addr_match;
  logic                mode_write;
  logic                gain_write;

  // State decodes shared by the shifter and bit counter blocks
  assign in_addr    = (state_ff == igm_pkg::IGM_ADDR);
  assign in_aack    = (state_ff == igm_pkg::IGM_AACK);
  assign in_data    = (state_ff == igm_pkg::IGM_DATA);
  assign in_dack    = (state_ff == igm_pkg::IGM_DACK);
  assign in_byte    = in_addr || in_data;
  assign in_ack     = in_aack || in_dack;
  // START or STOP outranks any clock edge seen in the same cycle
  assign bus_event  = line.start_det || line.stop_det;
  assign byte_full  = (bit_cnt_ff == 4'h8);
  assign take_bit   = in_byte && line.scl_rise && !byte_full;
  // Whole byte compare, so a read bit of one never matches
  assign addr_match = (shift_ff == `IGM_DEV_ADDR_BYTE);
  assign mode_write = commit && !shift_ff[`IGM_SEL_BIT];
  assign gain_write = commit && shift_ff[`IGM_SEL_BIT];
  // Commit when the acknowledge clock falls, never on a partial byte
  assign commit    = (state_ff == igm_pkg::IGM_DACK) && line.scl_fall;

  always_comb begin
    nxt_state = state_ff;
    if (line.start_det) begin
      nxt_state = igm_pkg::IGM_ADDR;
    end else if (line.stop_det) begin
      nxt_state = igm_pkg::IGM_IDLE;
    end else begin
      case (state_ff)
        igm_pkg::IGM_IDLE: begin
          nxt_state = igm_pkg::IGM_IDLE;
        end
        igm_pkg::IGM_ADDR: begin
          if (line.scl_fall && bit_cnt_ff == 4'h8) begin
            // Mismatch or read: release and wait for START
            if (addr_match) begin
              nxt_state = igm_pkg::IGM_AACK;
            end else begin
              nxt_state = igm_pkg::IGM_IDLE;
            end
          end
        end
        igm_pkg::IGM_AACK: begin
          if (line.scl_fall) begin
            nxt_state = igm_pkg::IGM_DATA;
          end
        end
        igm_pkg::IGM_DATA: begin
          if (line.scl_fall && bit_cnt_ff == 4'h8) begin
            nxt_state = igm_pkg::IGM_DACK;
          end
        end
        igm_pkg::IGM_DACK: begin
          if (line.scl_fall) begin
            nxt_state = igm_pkg::IGM_DATA;
          end
        end
        default: begin
          nxt_state = igm_pkg::IGM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= igm_pkg::IGM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit counter; cleared on START, STOP and each byte boundary
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_cnt_ff <= 4'h0;
    end else if (bus_event) begin
      bit_cnt_ff <= 4'h0;
    end else if (take_bit) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (in_ack && line.scl_fall) begin
      bit_cnt_ff <= 4'h0;
    end
  end

  // Shifter; a partial byte is wiped so it can never be committed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_ff <= 8'h00;
    end else if (bus_event) begin
      shift_ff <= 8'h00;
    end else if (take_bit) begin
      shift_ff <= {shift_ff[6:0], line.sda_level};
    end
  end

  // Acknowledge low from the fall after bit eight to the fall ending clock nine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_drive_ff <= 1'b0;
    end else if (line.start_det || line.stop_det) begin
      ack_drive_ff <= 1'b0;
    end else if (nxt_state == igm_pkg::IGM_AACK || nxt_state == igm_pkg::IGM_DACK) begin
      ack_drive_ff <= 1'b1;
    end else begin
      ack_drive_ff <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive_ff;

  // Power field; reserved mode bits simply have no storage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      power_ff <= 1'(`IGM_MODE_RESET >> `IGM_MODE_PWR_BIT);
    end else if (mode_write) begin
      power_ff <= shift_ff[`IGM_MODE_PWR_BIT];
    end
  end

  // Mute field
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mute_ff <= 1'(`IGM_MODE_RESET >> `IGM_MODE_MUTE_BIT);
    end else if (mode_write) begin
      mute_ff <= shift_ff[`IGM_MODE_MUTE_BIT];
    end
  end

  // Factory test field; honoured as written, the master must keep it zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      test_ff <= 1'(`IGM_MODE_RESET >> `IGM_MODE_TEST_BIT);
    end else if (mode_write) begin
      test_ff <= shift_ff[`IGM_MODE_TEST_BIT];
    end
  end

  // Gain code; bit 6 of the byte is reserved and dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_ff <= `IGM_GAIN_RESET;
    end else if (gain_write) begin
      gain_ff <= shift_ff[`IGM_GAIN_WIDTH-1:0];
    end
  end

  // Wake-up counter; held at zero in power-down, restarts on every exit from it
  always_ff @(posedge clk_sys) begin
    if (rst || !power_ff) begin
      wake_cnt_ff <= 32'h0000_0000;
    end else if (wake_cnt_ff < WAKE_CYCLES - 1) begin
      wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
    end
  end

  // Ready flag; held low until the full wake time has passed
  always_ff @(posedge clk_sys) begin
    if (rst || !power_ff) begin
      ready_ff <= 1'b0;
    end else if (wake_cnt_ff >= WAKE_CYCLES - 1) begin
      ready_ff <= 1'b1;
    end
  end

  assign power_down_select   = power_ff;
  assign mute_enable         = mute_ff;
  assign factory_test_enable = test_ff;
  assign gain_code           = gain_ff;
  assign amp_ready           = ready_ff;
  assign busy                = (state_ff != igm_pkg::IGM_IDLE);
endmodule : igm_slave
`default_nettype wire

/* File: igm_chk.sv */
// Port checker for igm_slave.
// Bound onto igm_slave; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "igm_defines.svh"
module igm_chk #(
  parameter int unsigned WAKE_CYCLES = `IGM_WAKE_CYCLES
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       power_down_select,
  input wire logic [5:0] gain_code,
  input wire logic       amp_ready,
  input wire logic       busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] on_ff;
  // Saturates so the full 5 ms count never wraps
  always_ff @(posedge clk_sys) begin
    if (rst || !power_down_select) on_ff <= '0;
    else if (on_ff < WAKE_CYCLES) on_ff <= on_ff + 32'h1;
  end
  drain_only_a: assert property (sda_out == 1'h0)
    else $error("data driven high");
  ack_clk_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("ack starts with clock high");
  ack_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("ack moved with clock high");
  idle_quiet_a: assert property (!busy |-> !sda_oe)
    else $error("ack while idle");
  commit_low_a: assert property (!$stable(gain_code) |-> !scl_in && $past(busy))
    else $error("gain changed outside ack end");
  start_busy_a: assert property ($rose(busy) |-> scl_in && !sda_in)
    else $error("busy without start");
  stop_idle_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:3] !busy)
    else $error("stop did not idle");
  wake_wait_a: assert property (amp_ready && power_down_select |-> on_ff + 2 >= WAKE_CYCLES)
    else $error("ready before wake time");
  sleep_drop_a: assert property ($fell(power_down_select) |-> ##[0:1] !amp_ready)
    else $error("ready kept in power-down");
endmodule : igm_chk
bind igm_slave igm_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.clk_sys(clk_sys), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
  .power_down_select(power_down_select), .gain_code(gain_code), .amp_ready(amp_ready));
`default_nettype wire

/* File: igm_master.sv */
// Bus master model, four clk_sys cycles per clock phase.
// Assumes a pull-up resolves sda_bus outside.
`timescale 1ns/1ps
`default_nettype none
module igm_master (
  input  wire logic clk_sys,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_bus
);
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold
  // Start when stp low, stop when high; usable from any clock level
  task automatic cond(input logic stp);
    sda_drv <= ~stp;
    hold(2);
    scl <= 1'h1;
    hold(4);
    sda_drv <= stp;
    hold(4);
    if (!stp) begin
      scl <= 1'h0;
      hold(1);
    end
  endtask : cond
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sda_drv <= b[i];
      hold(3);
      scl <= 1'h1;
      hold(4);
      scl <= 1'h0;
      hold(1);
    end
  endtask : bits
  task automatic xfer(input logic [7:0] b, output logic ack);
    bits(b, 8);
    sda_drv <= 1'h1;
    hold(3);
    scl <= 1'h1;
    hold(2);
    ack = ~sda_bus;
    hold(2);
    scl <= 1'h0;
    hold(1);
  endtask : xfer
endmodule : igm_master
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for igm_slave driven by the master model.
// Assumes a 20-cycle wake count in place of 5 ms.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys, rst, scl, sda_drv, sda_in, sda_out, sda_oe, ack;
  logic       power_down_select, mute_enable, factory_test_enable, amp_ready, busy;
  logic [5:0] gain_code;
  logic [7:0] bad [2] = '{8'hDF, 8'hDC};
  int         err_total, comparisons;
  // Pull-up: released line reads high
  assign sda_in = sda_drv & (sda_out | ~sda_oe);
  igm_slave #(.WAKE_CYCLES(20)) DUT (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .amp_ready(amp_ready),
    .power_down_select(power_down_select), .mute_enable(mute_enable),
    .factory_test_enable(factory_test_enable), .gain_code(gain_code));
  igm_master m (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv), .sda_bus(sda_in));
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic wr(input logic [7:0] b, input logic exp);
    m.xfer(b, ack);
    check(ack, exp, "ack");
  endtask : wr
  // Two edges let a late amp_ready update land
  task automatic st(input logic [9:0] exp);
    repeat (2) @(posedge clk_sys);
    check({amp_ready, factory_test_enable, mute_enable, power_down_select, gain_code},
          exp, "registers");
  endtask : st
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    #40000;
    err_total++;
    $display("MISMATCH %0t watchdog", $time);
    summarize();
  end
  initial begin
    rst = 1'h1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    st(10'h000);
    m.cond(1'h0);
    wr(8'hDE, 1'h1);
    wr(8'h6D, 1'h1);
    st(10'h040);
    wr(8'hFF, 1'h1);
    st(10'h27F);
    wr(8'h12, 1'h1);
    st(10'h1BF);
    m.cond(1'h1);
    check(busy, 10'h000, "stop");
    $display("test 1 done");
    for (int i = 0; i < 2; i++) begin
      m.cond(1'h0);
      wr(bad[i], 1'h0);
      wr(8'h81, 1'h0);
      m.cond(1'h1);
    end
    wr(8'h81, 1'h0);
    st(10'h1BF);
    $display("test 2 done");
    m.cond(1'h0);
    wr(8'hDE, 1'h1);
    m.bits(8'h81, 5);
    m.cond(1'h0);
    wr(8'hDE, 1'h1);
    wr(8'h80, 1'h1);
    st(10'h180);
    wr(8'h81, 1'h1);
    st(10'h181);
    wr(8'h03, 1'h1);
    st(10'h0C1);
    m.cond(1'h1);
    $display("test 3 done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
